// file: hdl/pil_preset_input_latch.sv
`timescale 1ns/1ps
`include "pil_consts.svh"

module pil_preset_input_latch (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Preset control
  input wire logic global_preset_clear,
  input wire logic preset_invert,
  // Pad side
  input wire logic latch_allow,
  input wire logic gate_in,
  input wire logic data_in,
  // Stored outputs
  output pil_pkg::pil_q_t q
);
  import pil_pkg::*;

  // ----------------------------------------
  // Preset decode
  // ----------------------------------------
  // Async set path: keep the preset source glitch free at the board level
  logic preset_act;
  assign preset_act = global_preset_clear ^ preset_invert; // see R06

  pil_q_t q_r;
  logic gate_prev_r;
  logic rise_ev;
  logic fall_ev;

  assign rise_ev = latch_allow && !gate_prev_r && gate_in;
  assign fall_ev = latch_allow && gate_prev_r && !gate_in;
  assign q = q_r;

  // ----------------------------------------
  // Gate history
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_prev_r <= `PIL_GATE_HIST_RST;
    end else if (ce) begin
      gate_prev_r <= gate_in;
    end
  end

  // ----------------------------------------
  // Latches and paired edge flops
  // ----------------------------------------
  // Gate is sampled, not registered, so transparency starts at the first clock edge that sees it high
  always_ff @(posedge clk or posedge preset_act) begin
    if (preset_act) begin
      q_r <= {4{`PIL_PRESET_VAL}}; // see R05
    end else if (!rst_n) begin
      q_r <= {4{`PIL_PRESET_VAL}}; // see R04
    end else if (ce && latch_allow) begin // see R08
      if (gate_in) begin
        q_r.latch_q <= data_in; // see R01
      end
      if (!gate_in) begin
        q_r.latch_low_q <= data_in; // see R03
      end
      if (fall_ev) begin
        q_r.fall_q <= q_r.latch_q; // see R02, R07
      end
      if (rise_ev) begin
        q_r.rise_q <= q_r.latch_low_q; // see R03, R07
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_follow;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && latch_allow && gate_in) |=> (q.latch_q == $past(data_in));
  endproperty
  a_follow: assert property (p_follow) else $error("latch did not follow data"); // see R01

  property p_hold;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && !gate_in) |=> $stable(q.latch_q);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed with gate low"); // see R02

  property p_fall_capture;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && latch_allow && gate_in) ##1 (ce && latch_allow && !gate_in)
      |=> (q.latch_q == $past(data_in, 2));
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("fall capture lost"); // see R02

  // ----------------------------------------
  // Checks: low gate
  // ----------------------------------------
  property p_low_follow;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && latch_allow && !gate_in) |=> (q.latch_low_q == $past(data_in));
  endproperty
  a_low_follow: assert property (p_low_follow) else $error("low gate latch wrong"); // see R03

  property p_low_hold;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && gate_in) |=> $stable(q.latch_low_q);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low gate latch moved"); // see R03

  property p_rise_capture;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && latch_allow && !gate_in) ##1 (ce && latch_allow && gate_in)
      |=> (q.latch_low_q == $past(data_in, 2));
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rise capture lost"); // see R03

  property p_rise_quiet;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (!(ce && rise_ev)) |=> $stable(q.rise_q);
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("rising flop moved"); // see R03

  // ----------------------------------------
  // Checks: preset, reset and edge pairing
  // ----------------------------------------

  property p_power_on;
    @(posedge clk) (!rst_n) |=> (q == {4{`PIL_PRESET_VAL}});
  endproperty
  a_power_on: assert property (p_power_on) else $error("reset did not preset"); // see R04

  // Reset must win over a low enable
  property p_rst_over_ce;
    @(posedge clk) (!rst_n && !ce) |=> (q == {4{`PIL_PRESET_VAL}});
  endproperty
  a_rst_over_ce: assert property (p_rst_over_ce) else $error("reset lost to enable"); // see R04

  property p_hist_reset;
    @(posedge clk) (!rst_n) |=> (gate_prev_r == `PIL_GATE_HIST_RST);
  endproperty
  a_hist_reset: assert property (p_hist_reset) else $error("gate history not reset"); // see R04

  property p_preset;
    @(posedge clk) (global_preset_clear && !preset_invert) |-> (q == {4{`PIL_PRESET_VAL}});
  endproperty
  a_preset: assert property (p_preset) else $error("preset not forced high"); // see R05

  property p_preset_inv;
    @(posedge clk) (!global_preset_clear && preset_invert) |-> (q == {4{`PIL_PRESET_VAL}});
  endproperty
  a_preset_inv: assert property (p_preset_inv) else $error("inverted preset failed"); // see R06

  property p_pair;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && fall_ev) |=> (q.fall_q == q.latch_q) ##0 (q.fall_q == $past(q.latch_q));
  endproperty
  a_pair: assert property (p_pair) else $error("falling flop not paired"); // see R07

  property p_rise_pair;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (ce && rise_ev) |=> (q.rise_q == q.latch_low_q) ##0 (q.rise_q == $past(q.latch_low_q));
  endproperty
  a_rise_pair: assert property (p_rise_pair) else $error("rising flop not paired"); // see R07

  property p_fall_quiet;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (!(ce && fall_ev)) |=> $stable(q.fall_q);
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("falling flop moved"); // see R07

  property p_edge_excl;
    @(posedge clk) disable iff (!rst_n)
    !(rise_ev && fall_ev);
  endproperty
  a_edge_excl: assert property (p_edge_excl) else $error("both gate edges at once"); // see R07

  // ----------------------------------------
  // Checks: freeze
  // ----------------------------------------

  property p_freeze;
    @(posedge clk) disable iff (!rst_n || preset_act)
    (!latch_allow || !ce) |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen"); // see R08

  // Edge detection would drop an edge made while enable is low if history ran with enable low
  property p_hist_freeze;
    @(posedge clk) disable iff (!rst_n)
    (!ce) |=> $stable(gate_prev_r);
  endproperty
  a_hist_freeze: assert property (p_hist_freeze) else $error("gate history moved"); // see R08

  property p_allow_hist;
    @(posedge clk) disable iff (!rst_n)
    (ce && !latch_allow) |=> (gate_prev_r == $past(gate_in));
  endproperty
  a_allow_hist: assert property (p_allow_hist) else $error("gate history stalled"); // see R08

  // ----------------------------------------
  // Coverage
  // ----------------------------------------

  c_fall: cover property (@(posedge clk) disable iff (!rst_n) ce && fall_ev);
  c_rise: cover property (@(posedge clk) disable iff (!rst_n) ce && rise_ev);
  c_preset: cover property (@(posedge clk) preset_act ##1 !preset_act);
  c_zero: cover property (@(posedge clk) disable iff (!rst_n) q.latch_q == 1'b0);
  c_ce_low: cover property (@(posedge clk) disable iff (!rst_n) !ce && latch_allow);

endmodule

// file: hdl/pil_consts.svh
// Function
// R01: True-gate latch follows data while allowed and gate high; holds when gate low.
// R02: True-gate latch keeps the value present at gate fall until next transparency.
// R03: Low-gate latch follows data while allowed and gate low; captures at rise.
// R04: All outputs forced high at power-on regardless of gate, allow or data.
// R05: Global preset/clear forces outputs high asynchronously while it is active.
// R06: Global preset/clear active high by default; polarity may be inverted.
// R07: Edge outputs pair: true-gate with falling flop, low-gate with rising flop.
// R08: While latch allow is low every latch output holds its value.
`ifndef PIL_CONSTS_SVH
`define PIL_CONSTS_SVH

// ----------------------------------------
// Preset values
// ----------------------------------------
`define PIL_PRESET_VAL 1'b1
`define PIL_GATE_HIST_RST 1'b0

`endif

// file: hdl/pil_pkg.sv
package pil_pkg;

  // ----------------------------------------
  // Output bundle
  // ----------------------------------------
  typedef struct packed {
    logic latch_q;
    logic latch_low_q;
    logic rise_q;
    logic fall_q;
  } pil_q_t;

endpackage

// file: sim/pil_pad_model.sv
`timescale 1ns/1ps

module pil_pad_model (
  // Level the pad carries
  input wire logic level,
  // Into the block
  output logic data_in
);
  // A bare pad has no storage, so the line simply follows
  assign data_in = level;
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps

module tb;
  import pil_pkg::*;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic clk = 0, rst_n = 0, ce = 1, gpc = 0, inv = 0, allow = 0, gate = 0, lvl = 0, data_in;
  pil_q_t q;
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #10 clk = ~clk;
  pil_pad_model pil_pad_model_i (.level(lvl), .data_in(data_in));
  pil_preset_input_latch pil_preset_input_latch_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .global_preset_clear(gpc), .preset_invert(inv), .latch_allow(allow), .gate_in(gate),
    .data_in(data_in), .q(q));
  task chk(input pil_q_t e);
    comparisons++;
    if (q !== e) begin
      miscompares++;
      $display("mismatch at %0t: q %h expected %h", $time, q, e);
    end
  endtask
  // Inputs move at the falling edge, q is read just after the rising one
  task step(input logic a, input logic g, input logic d);
    @(negedge clk);
    allow = a;
    gate = g;
    lvl = d;
    @(posedge clk);
    #1;
  endtask
  task t_reset;
    repeat (20) @(negedge clk);
    chk(4'hf);
    rst_n = 1;
    step(0, 0, 0);
    chk(4'hf);
  endtask
  task t_gates;
    step(1, 1, 0);
    chk(4'h7);
    step(1, 0, 1);
    chk(4'h6);
    step(1, 0, 0);
    chk(4'h2);
    step(1, 1, 1);
    chk(4'h8);
  endtask
  task t_allow;
    step(0, 0, 0);
    chk(4'h8);
    step(0, 1, 1);
    chk(4'h8);
  endtask
  task t_preset;
    @(negedge clk);
    gpc = 1;
    #1;
    chk(4'hf);
    step(1, 1, 0);
    chk(4'hf);
    @(negedge clk);
    gpc = 0;
    step(1, 1, 0);
    chk(4'h7);
    @(negedge clk);
    inv = 1;
    #1;
    chk(4'hf);
    @(negedge clk);
    gpc = 1;
    step(1, 1, 0);
    chk(4'h7);
  endtask
  task t_enable;
    @(negedge clk);
    ce = 0;
    step(1, 0, 1);
    chk(4'h7);
    @(negedge clk);
    ce = 1;
    @(posedge clk);
    #1;
    chk(4'h6);
    step(1, 0, 1);
    chk(4'h6);
  endtask
  task t_midreset;
    @(negedge clk);
    rst_n = 0;
    @(posedge clk);
    #1;
    chk(4'hf);
    @(negedge clk);
    rst_n = 1;
    @(posedge clk);
    #1;
    chk(4'hf);
    step(1, 1, 0);
    chk(4'h7);
  endtask
  task close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is about 42 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    t_reset;
    t_gates;
    t_allow;
    t_preset;
    t_enable;
    t_midreset;
    close_out;
  end
endmodule
